// File: rtl/esa_dev.sv
// Device end: nonvolatile parameter store with shadow copy, unlock key,
// write locks with user-word exceptions, and staged extended write.
// Assumes the host holds each link request until the one-cycle ack.
//
// Operation
// - Power-up copies every stored word into shadow.
// - Extended write to shadow leaves store untouched.
// - Shadow has store layout, addressed 0x40 higher.
// - Unused store bits absent in shadow, read 0.
// - Shadow omits the check bits.
// - Shadow writes get same protection checks, except lock 0xC.
// - Reads always succeed whatever the lock state.
// - Five key bytes to key register unlock writes.
// - Unlock holds until the next power-on reset.
// - Lock code 0xC blocks store, allows shadow.
// - Lock code 0x3 blocks store and shadow.
// - Either lock holds until reset clears the store; protect field frozen.
// - Exception fields default zero, no exceptions.
// - Unlocked part: bypass frees user words keylessly.
// - Locked part: override frees user words only.
// - Locked part: all other store words never writable.
// - Host first stages the 8-bit target address.
// - Host then stages the 32 data bits.
// - Trigger bit moves staged data to target.
// - Done bit on completion; store takes 24 ms.
// - Shadow write completes one cycle after trigger.
// - Refused target ends transfer, sets done and error.
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module esa_dev
    import esa_pkg::*;
#(
    parameter int NVW_CYCLES = `ESA_NVW_CYCLES
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Link from the host
    esa_if.dev               lnk,
    // Operating parameter read port
    input  wire logic [4:0]  param_sel,
    output logic      [23:0] param_q,
    // Status
    output logic             write_busy,
    output logic             unlocked
);

    esa_dev_reg_t r;
    esa_dev_reg_t next_r;

    // Write permission for one word, from the stored protect word
    function automatic logic write_ok(input logic [4:0] idx, input logic shadow,
                                      input logic [31:0] cfg, input logic unl);
        logic [3:0] lk;
        logic       locked;
        logic       user;
        lk = cfg[`ESA_LOCK_MSB:`ESA_LOCK_LSB];
        // Store lock only bites store words; full lock bites both
        locked = ((lk == `ESA_LOCK_NV) && !shadow) || (lk == `ESA_LOCK_ALL);
        user   = (idx == `ESA_UW2_IDX) || ((idx == `ESA_UW1_IDX) && cfg[`ESA_CUD_BIT]);
        if (locked) begin
            // Protect word itself is no user word, so it stays frozen
            write_ok = user && cfg[`ESA_DEL_BIT] && (cfg[`ESA_DUR_BIT] || unl);
        end else begin
            write_ok = unl || (user && cfg[`ESA_DUR_BIT]);
        end
    endfunction

    // Expected key byte for a match position
    function automatic logic [7:0] key_byte(input logic [2:0] i);
        case (i)
            3'h0:    key_byte = `ESA_KEY0;
            3'h1:    key_byte = `ESA_KEY1;
            3'h2:    key_byte = `ESA_KEY2;
            3'h3:    key_byte = `ESA_KEY3;
            default: key_byte = `ESA_KEY4;
        endcase
    endfunction

    // Next state: link decode, key matcher, power-up load, write engine
    always_comb begin
        logic       take;
        logic       trig;
        logic       to_sh;
        logic       to_nv;
        logic [4:0] widx;
        logic [7:0] st_byte;
        take    = lnk.req && !r.ack;
        trig    = 1'b0;
        to_sh   = (r.ewa >= `ESA_SHADOW_OFS) && (r.ewa <= (`ESA_SHADOW_OFS + 8'h1F));
        to_nv   = r.ewa <= 8'h1F;
        widx    = r.ewa[4:0];
        st_byte = {5'b00000, r.unlocked, r.xee, r.wdn};
        next_r  = r;
        next_r.ack = 1'b0;
        // Shadow read is free of any lock check; upper bits read zero
        next_r.param_q = r.sh[param_sel];

        // Direct register access, one per request
        if (take) begin
            next_r.ack = 1'b1;
            if (lnk.wr) begin
                case (lnk.addr)
                    `ESA_DA_EWA:  next_r.ewa         = lnk.wdata;
                    `ESA_DA_EWD0: next_r.ewd[31:24]  = lnk.wdata;
                    `ESA_DA_EWD1: next_r.ewd[23:16]  = lnk.wdata;
                    `ESA_DA_EWD2: next_r.ewd[15:8]   = lnk.wdata;
                    `ESA_DA_EWD3: next_r.ewd[7:0]    = lnk.wdata;
                    `ESA_DA_EWCS: trig = lnk.wdata[`ESA_EWCS_EXW];
                    `ESA_DA_KEY: begin
                        // Once open, the key register no longer matters
                        if (!r.unlocked) begin
                            if (lnk.wdata == key_byte(r.key_idx)) begin
                                if (r.key_idx == 3'h4) begin
                                    next_r.unlocked = 1'b1;
                                    next_r.key_idx  = 3'h0;
                                end else begin
                                    next_r.key_idx = 3'(r.key_idx + 3'h1);
                                end
                            end else begin
                                // A breaking byte may itself open a new attempt
                                next_r.key_idx = (lnk.wdata == `ESA_KEY0) ? 3'h1 : 3'h0;
                            end
                        end
                    end
                    default: ;
                endcase
            end else begin
                case (lnk.addr)
                    `ESA_DA_EWA:  next_r.rdata = r.ewa;
                    `ESA_DA_EWD0: next_r.rdata = r.ewd[31:24];
                    `ESA_DA_EWD1: next_r.rdata = r.ewd[23:16];
                    `ESA_DA_EWD2: next_r.rdata = r.ewd[15:8];
                    `ESA_DA_EWD3: next_r.rdata = r.ewd[7:0];
                    `ESA_DA_EWST: next_r.rdata = st_byte;
                    default:      next_r.rdata = 8'h00;
                endcase
            end
        end

        // Sequencer
        case (r.state)
            ESA_D_LOAD: begin
                // Only data bits travel; check bits stay in the store
                next_r.sh[r.load_idx] = r.nv[r.load_idx][`ESA_DATA_MSB:0];
                next_r.load_idx       = 5'(r.load_idx + 5'h01);
                if (r.load_idx == `ESA_NV_LAST) begin
                    next_r.state = ESA_D_IDLE;
                end
            end
            ESA_D_IDLE: begin
                // A trigger while busy or loading is dropped on purpose
                if (trig) begin
                    next_r.wdn = 1'b0;
                    next_r.xee = 1'b0;
                    if (!(to_sh || to_nv) ||
                        !write_ok(widx, to_sh, r.nv[`ESA_CFG_IDX], r.unlocked)) begin
                        next_r.wdn = 1'b1;
                        next_r.xee = 1'b1;
                    end else if (to_sh) begin
                        next_r.state = ESA_D_SHW;
                    end else begin
                        next_r.tmr   = 20'(NVW_CYCLES - 1);
                        next_r.state = ESA_D_NVW;
                    end
                end
            end
            ESA_D_SHW: begin
                // Store copy is left alone; the shadow change is temporary
                next_r.sh[widx] = r.ewd[`ESA_DATA_MSB:0];
                next_r.wdn      = 1'b1;
                next_r.state    = ESA_D_IDLE;
            end
            ESA_D_NVW: begin
                // Programming time modelled as a plain wait; shadow untouched
                if (r.tmr == 20'h00000) begin
                    next_r.nv[widx] = r.ewd;
                    next_r.wdn      = 1'b1;
                    next_r.state    = ESA_D_IDLE;
                end else begin
                    next_r.tmr = 20'(r.tmr - 20'h00001);
                end
            end
            default: next_r.state = ESA_D_IDLE;
        endcase
        // Busy kept in its own flop so the status pin needs no decode
        next_r.busy = (next_r.state != ESA_D_IDLE);
    end

    // State register; store cleared at power-on, so exceptions start off
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r       <= '0;
            r.nv    <= {32{`ESA_NV_RESET}};
            r.state <= ESA_D_LOAD;
            r.busy  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign lnk.ack    = r.ack;
    assign lnk.rdata  = r.rdata;
    assign param_q    = r.param_q;
    assign write_busy = r.busy;
    assign unlocked   = r.unlocked;

endmodule
`default_nettype wire

// File: rtl/esa_consts.svh
// Constants for the nonvolatile store access block: direct register map,
// key bytes, lock codes, store layout, timing and host register map.
// Assumes a 20 MHz mclk; included by both ends, the checker and the testbench.
`ifndef ESA_CONSTS_SVH
`define ESA_CONSTS_SVH

// Direct registers of the device (byte addresses on the link)
`define ESA_DA_EWA      6'h03
`define ESA_DA_EWD0     6'h04
`define ESA_DA_EWD1     6'h05
`define ESA_DA_EWD2     6'h06
`define ESA_DA_EWD3     6'h07
`define ESA_DA_EWCS     6'h08
`define ESA_DA_EWST     6'h09
`define ESA_DA_KEY      6'h3C

// Field positions in the direct control and status bytes
`define ESA_EWCS_EXW    7
`define ESA_EWCS_TRIG   8'h80
`define ESA_ST_WDN      0
`define ESA_ST_XEE      1
`define ESA_ST_UNL      2

// Unlock key, sent in this order to the key register upper byte
`define ESA_KEY0        8'h00
`define ESA_KEY1        8'h27
`define ESA_KEY2        8'h81
`define ESA_KEY3        8'h1F
`define ESA_KEY4        8'h77

// Store layout: 32 words, shadow copy 0x40 above
`define ESA_SHADOW_OFS  8'h40
`define ESA_NV_LAST     5'h1F
`define ESA_DATA_MSB    23
`define ESA_UW2_IDX     5'h17
`define ESA_UW1_IDX     5'h1F
`define ESA_CFG_IDX     5'h1D
`define ESA_LOCK_MSB    3
`define ESA_LOCK_LSB    0
`define ESA_CUD_BIT     4
`define ESA_DEL_BIT     5
`define ESA_DUR_BIT     6
`define ESA_LOCK_NV     4'hC
`define ESA_LOCK_ALL    4'h3
`define ESA_NV_RESET    32'h0000_0000

// Timing
`define ESA_CLK_HZ      20000000
`define ESA_NVW_MS      24
`define ESA_NVW_CYCLES  (`ESA_NVW_MS * (`ESA_CLK_HZ / 1000))

// Host registers on APB (byte addresses)
`define ESA_HA_ADDR     12'h000
`define ESA_HA_DATA     12'h004
`define ESA_HA_CMD      12'h008
`define ESA_HA_STAT     12'h00C
`define ESA_CMD_UNLOCK  0
`define ESA_CMD_WRITE   1
`define ESA_HS_BUSY     0
`define ESA_HS_DONE     1
`define ESA_HS_XEE      2
`define ESA_HS_UNL      3

// Host sequence steps
`define ESA_STEP_UNL_POLL 4'h5
`define ESA_STEP_WR_POLL  4'h6

`endif

// File: rtl/esa_pkg.sv
// Types shared by both ends of the nonvolatile store access link.
// Assumes the constants header sits beside it.
package esa_pkg;

    // Device sequencer
    typedef enum logic [1:0] {
        ESA_D_LOAD = 2'b00,
        ESA_D_IDLE = 2'b01,
        ESA_D_SHW  = 2'b10,
        ESA_D_NVW  = 2'b11
    } esa_dev_state_t;

    // Host sequencer
    typedef enum logic [1:0] {
        ESA_H_IDLE = 2'b00,
        ESA_H_SEND = 2'b01,
        ESA_H_GAP  = 2'b10
    } esa_host_state_t;

    // Whole device state
    typedef struct packed {
        esa_dev_state_t    state;
        logic [31:0][31:0] nv;
        logic [31:0][23:0] sh;
        logic [4:0]        load_idx;
        logic              unlocked;
        logic [2:0]        key_idx;
        logic [7:0]        ewa;
        logic [31:0]       ewd;
        logic              wdn;
        logic              xee;
        logic [19:0]       tmr;
        logic              ack;
        logic [7:0]        rdata;
        logic [23:0]       param_q;
        logic              busy;
    } esa_dev_reg_t;

    // Whole host state
    typedef struct packed {
        esa_host_state_t state;
        logic            op_write;
        logic [3:0]      step;
        logic            req;
        logic            wr;
        logic [5:0]      addr;
        logic [7:0]      wdata;
        logic [7:0]      ext_addr;
        logic [31:0]     ext_data;
        logic            busy;
        logic            done;
        logic            xee;
        logic            unl;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } esa_host_reg_t;

endpackage

// File: rtl/esa_if.sv
// Direct register link between the host controller and the device.
// Assumes both ends run on the same mclk; one request at a time.
`timescale 1ns/1ps
`default_nettype none
interface esa_if;
    logic       req;    // Request level, held until ack
    logic       wr;     // 1 write, 0 read
    logic [5:0] addr;   // Direct register byte address
    logic [7:0] wdata;  // Write byte
    logic       ack;    // One-cycle answer pulse
    logic [7:0] rdata;  // Read byte, valid with ack

    modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
    modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// File: rtl/esa_host.sv
// Host controller: takes orders over APB and drives the direct link
// with the unlock key and the staged extended write sequence.
// Assumes the device answers each request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module esa_host
    import esa_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the device
    esa_if.host              lnk
);

    esa_host_reg_t r;
    esa_host_reg_t next_r;

    // Request for one step: {wr, addr, data}
    function automatic logic [14:0] step_cmd(input logic op_w, input logic [3:0] st,
                                             input logic [7:0] ea, input logic [31:0] ed);
        logic [14:0] c;
        c = {1'b0, `ESA_DA_EWST, 8'h00};
        if (!op_w) begin
            case (st)
                4'h0: c = {1'b1, `ESA_DA_KEY, `ESA_KEY0};
                4'h1: c = {1'b1, `ESA_DA_KEY, `ESA_KEY1};
                4'h2: c = {1'b1, `ESA_DA_KEY, `ESA_KEY2};
                4'h3: c = {1'b1, `ESA_DA_KEY, `ESA_KEY3};
                4'h4: c = {1'b1, `ESA_DA_KEY, `ESA_KEY4};
                default: c = {1'b0, `ESA_DA_EWST, 8'h00};
            endcase
        end else begin
            case (st)
                4'h0: c = {1'b1, `ESA_DA_EWA, ea};
                4'h1: c = {1'b1, `ESA_DA_EWD0, ed[31:24]};
                4'h2: c = {1'b1, `ESA_DA_EWD1, ed[23:16]};
                4'h3: c = {1'b1, `ESA_DA_EWD2, ed[15:8]};
                4'h4: c = {1'b1, `ESA_DA_EWD3, ed[7:0]};
                4'h5: c = {1'b1, `ESA_DA_EWCS, `ESA_EWCS_TRIG};
                default: c = {1'b0, `ESA_DA_EWST, 8'h00};
            endcase
        end
        return c;
    endfunction

    // Next state: APB slave and link sequencer
    always_comb begin
        logic [14:0] c;
        logic        last;
        c      = '0;
        last   = 1'b0;
        next_r = r;
        next_r.pready = 1'b0;
        // Answer one cycle into the access phase so prdata comes from a flop
        if (psel && penable && !r.pready) begin
            next_r.pready  = 1'b1;
            next_r.pslverr = 1'b0;
            next_r.prdata  = 32'h0000_0000;
            case (paddr)
                `ESA_HA_ADDR: next_r.prdata = {24'h00_0000, r.ext_addr};
                `ESA_HA_DATA: next_r.prdata = r.ext_data;
                `ESA_HA_CMD:  next_r.prdata = 32'h0000_0000;
                `ESA_HA_STAT: next_r.prdata = {28'h000_0000, r.unl, r.xee, r.done, r.busy};
                default:      next_r.pslverr = 1'b1;
            endcase
        end
        // Writes land only at the edge where the master sees pready high
        if (psel && penable && pwrite && r.pready) begin
            case (paddr)
                `ESA_HA_ADDR: next_r.ext_addr = pwdata[7:0];
                `ESA_HA_DATA: next_r.ext_data = pwdata;
                `ESA_HA_CMD: begin
                    // Orders while busy are dropped; software polls busy first
                    if (!r.busy && (pwdata[`ESA_CMD_WRITE] || pwdata[`ESA_CMD_UNLOCK])) begin
                        next_r.op_write = pwdata[`ESA_CMD_WRITE];
                        next_r.step     = 4'h0;
                        next_r.busy     = 1'b1;
                        next_r.done     = 1'b0;
                        next_r.state    = ESA_H_GAP;
                    end
                end
                default: ;
            endcase
        end
        case (r.state)
            ESA_H_IDLE: begin
                next_r.req = 1'b0;
            end
            ESA_H_GAP: begin
                c              = step_cmd(r.op_write, r.step, r.ext_addr, r.ext_data);
                next_r.wr      = c[14];
                next_r.addr    = c[13:8];
                next_r.wdata   = c[7:0];
                next_r.req     = 1'b1;
                next_r.state   = ESA_H_SEND;
            end
            ESA_H_SEND: begin
                if (lnk.ack) begin
                    next_r.req   = 1'b0;
                    next_r.state = ESA_H_GAP;
                    if (!r.wr) begin
                        next_r.xee = lnk.rdata[`ESA_ST_XEE];
                        next_r.unl = lnk.rdata[`ESA_ST_UNL];
                        // Write waits for the done bit; unlock reads once
                        last = !r.op_write || lnk.rdata[`ESA_ST_WDN];
                    end else begin
                        next_r.step = 4'(r.step + 4'h1);
                    end
                    if (last) begin
                        next_r.busy  = 1'b0;
                        next_r.done  = 1'b1;
                        next_r.state = ESA_H_IDLE;
                    end
                end
            end
            default: next_r.state = ESA_H_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r       <= '0;
            r.state <= ESA_H_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;
    assign lnk.req   = r.req;
    assign lnk.wr    = r.wr;
    assign lnk.addr  = r.addr;
    assign lnk.wdata = r.wdata;

endmodule
`default_nettype wire

// File: verification/esa_link_asserts.sv
// Checker for the direct link between host and device ends.
// Assumes one mclk domain; instantiated beside the interface in tb_top.
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module esa_link_asserts #(
    parameter int NVW_CYCLES = 20
)
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Link signals
    input  wire logic       req,
    input  wire logic       wr,
    input  wire logic [5:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       ack,
    input  wire logic [7:0] rdata,
    // Device status
    input  wire logic       write_busy,
    input  wire logic       unlocked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Longest busy span: power-up load or one store write, plus slack
    localparam int BUSY_MAX = ((NVW_CYCLES > 32) ? NVW_CYCLES : 32) + 4;
    logic [19:0] busy_cnt;

    // Busy run length, cleared whenever the device goes idle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= 20'h00000;
        end else begin
            busy_cnt <= write_busy ? busy_cnt + 20'h00001 : 20'h00000;
        end
    end

    property p_ack_next;
        req && !ack |=> ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("link ack late");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("link ack too long");
    property p_ack_cause;
        ack |-> $past(req && !ack);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("link ack without request");
    property p_req_hold;
        req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("link request changed early");
    property p_req_drop;
        ack |=> !req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("link request held after ack");
    property p_unl_hold;
        unlocked |=> unlocked;
    endproperty
    a_unl_hold: assert property (p_unl_hold) else $error("unlock lost");
    property p_unl_key;
        $rose(unlocked) |-> $past(req && wr && addr == `ESA_DA_KEY && wdata == `ESA_KEY4)
            || $past(req && wr && addr == `ESA_DA_KEY && wdata == `ESA_KEY4, 2);
    endproperty
    a_unl_key: assert property (p_unl_key) else $error("unlock without last key");
    property p_st_read;
        ack && $past(req && !wr && addr == `ESA_DA_EWST)
            |-> rdata[`ESA_ST_UNL] == unlocked && rdata[7:3] == 5'h00;
    endproperty
    a_st_read: assert property (p_st_read) else $error("status byte wrong");
    property p_load_busy;
        $rose(arst_n) |-> write_busy [*8];
    endproperty
    a_load_busy: assert property (p_load_busy) else $error("load not busy");
    property p_load_end;
        $rose(arst_n) |-> ##[1:40] !write_busy;
    endproperty
    a_load_end: assert property (p_load_end) else $error("load too long");
    property p_busy_len;
        busy_cnt <= 20'(BUSY_MAX);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Testbench: drives the host over APB and checks both ends together.
// Assumes store words reset to zero and a shortened store write time.
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module tb_top;
    logic        mclk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  param_sel;
    logic [23:0] param_q;
    logic        write_busy;
    logic        unlocked;
    logic [31:0] q;
    int          err_count;
    int          n_compared;

    esa_if i_esa_if ();
    esa_host i_esa_host (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(i_esa_if));
    esa_dev #(.NVW_CYCLES(20)) i_esa_dev (.mclk(mclk), .arst_n(arst_n), .lnk(i_esa_if),
        .param_sel(param_sel), .param_q(param_q), .write_busy(write_busy),
        .unlocked(unlocked));
    esa_link_asserts #(.NVW_CYCLES(20)) i_esa_link_asserts (.mclk(mclk), .arst_n(arst_n),
        .req(i_esa_if.req), .wr(i_esa_if.wr), .addr(i_esa_if.addr), .wdata(i_esa_if.wdata),
        .ack(i_esa_if.ack), .rdata(i_esa_if.rdata), .write_busy(write_busy),
        .unlocked(unlocked));

    // 20 MHz clock
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer; waits an edge first so back-to-back calls never
    // assign psel twice in one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Poll host status until the sequence is no longer busy
    task automatic wait_idle;
        repeat (400) begin
            apb(1'b0, `ESA_HA_STAT, 32'h0000_0000);
            if (q[`ESA_HS_BUSY] === 1'b0) break;
        end
        check("stat_busy", {31'h0, q[`ESA_HS_BUSY]}, 32'h0000_0000);
    endtask

    task automatic unlock;
        apb(1'b1, `ESA_HA_CMD, 32'h0000_0001);
        wait_idle();
        check("stat_unlocked", {31'h0, q[`ESA_HS_UNL]}, 32'h0000_0001);
        check("dev_unlocked", {31'h0, unlocked}, 32'h0000_0001);
    endtask

    // Staged extended write; expects done set and the given error flag
    task automatic op(input logic [7:0] ea, input logic [31:0] ed, input logic xe);
        apb(1'b1, `ESA_HA_ADDR, {24'h000000, ea});
        apb(1'b1, `ESA_HA_DATA, ed);
        apb(1'b1, `ESA_HA_CMD, 32'h0000_0002);
        wait_idle();
        check("stat_done", {31'h0, q[`ESA_HS_DONE]}, 32'h0000_0001);
        check("stat_error", {31'h0, q[`ESA_HS_XEE]}, {31'h0, xe});
    endtask

    task automatic check_sh(input logic [4:0] idx, input logic [23:0] exp);
        param_sel <= idx;
        repeat (2) @(posedge mclk);
        check("param_q", {8'h00, param_q}, {8'h00, exp});
    endtask

    // Reset, then let the power-up load finish before any trigger
    task automatic do_reset;
        arst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (60) begin
            @(posedge mclk);
            if (write_busy === 1'b0) break;
        end
        check("load_busy", {31'h0, write_busy}, 32'h0000_0000);
    endtask

    // Watchdog: the tests need well under 20000 cycles
    initial begin
        #(50 * 40000);
        err_count++;
        tally_and_finish();
    end

    initial begin
        err_count  = 0;
        n_compared = 0;
        arst_n     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        param_sel  = 5'h00;
        @(posedge mclk);
        do_reset();
        check("dev_unlocked", {31'h0, unlocked}, 32'h0000_0000);
        check_sh(5'h00, 24'h000000);
        apb(1'b1, 12'h010, 32'h0000_0000);
        check("pslverr", {31'h0, pslverr}, 32'h0000_0001);
        op(8'h45, 32'h0012_3456, 1'b1);
        check_sh(5'h05, 24'h000000);
        unlock();
        op(8'h45, 32'hFFA4_5678, 1'b0);
        check_sh(5'h05, 24'hA45678);
        op(8'h05, 32'h0011_1111, 1'b0);
        check_sh(5'h05, 24'hA45678);
        op(8'h20, 32'h0000_0000, 1'b1);
        op(8'h60, 32'h0000_0000, 1'b1);
        op(8'h1D, 32'h0000_000C, 1'b0);
        op(8'h05, 32'h0000_0000, 1'b1);
        op(8'h45, 32'h000A_BCDE, 1'b0);
        check_sh(5'h05, 24'h0ABCDE);
        op(8'h1D, 32'h0000_0000, 1'b1);
        op(8'h17, 32'h0000_0001, 1'b1);
        do_reset();
        check("dev_unlocked", {31'h0, unlocked}, 32'h0000_0000);
        check_sh(5'h05, 24'h000000);
        unlock();
        op(8'h1D, 32'h0000_0023, 1'b0);
        op(8'h45, 32'h0000_AAAA, 1'b1);
        check_sh(5'h05, 24'h000000);
        op(8'h17, 32'h0000_0005, 1'b0);
        op(8'h1F, 32'h0000_0005, 1'b1);
        do_reset();
        unlock();
        op(8'h1D, 32'h0000_003C, 1'b0);
        op(8'h1F, 32'h0000_0007, 1'b0);
        op(8'h5F, 32'h0000_0007, 1'b0);
        check_sh(5'h1F, 24'h000007);
        tally_and_finish();
    end
endmodule
`default_nettype wire
